// ---- byte_interval_timer.sv ----
// Two 8-bit interval timers with output control and port 3 direction
`timescale 1ns/1ps
module byte_interval_timer
   import byte_timer_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_bit_wr,
   input  wire logic [2:0]  reg_bit_sel,
   input  wire logic        reg_bit_val,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        ext_count_in_a,
   input  wire logic        ext_count_in_b,
   input  wire logic [7:0]  port3_in,
   output logic      [7:0]  port3_out,
   output logic      [7:0]  port3_oe,
   output logic             match_irq_a,
   output logic             match_irq_b
);

   // Whole module state in one record
   typedef struct packed {
      logic [PRESC_WIDTH-1:0] presc;        // Free-running prescaler
      logic [7:0]             clock_select; // Both clock fields
      logic [2:0]             mode;         // Enables and cascade
      logic                   out_enable_a;
      logic                   invert_enable_a;
      logic                   out_enable_b;
      logic                   invert_enable_b;
      logic [7:0]             port3_direction;
      logic [7:0]             port3_latch;
      logic [7:0]             compare_a;
      logic [7:0]             compare_b;
      logic [7:0]             counter_a;
      logic [7:0]             counter_b;
      logic                   output_latch_a; // Timer output flip-flop A
      logic                   output_latch_b; // Timer output flip-flop B
      logic                   irq_a;
      logic                   irq_b;
      logic [7:0]             rdata;
      logic [7:0]             pin_out;
      logic [7:0]             pin_oe;
      logic [1:0]             ext_s1;       // First sync stage, read only by ext_s2
      logic [1:0]             ext_s2;
      logic [1:0]             ext_s3;       // Previous value for edge detect
      logic [7:0]             pin_s1;       // First sync stage of port pins
      logic [7:0]             pin_s2;
   } state_type;

   state_type st;       // Registered state
   state_type next_st;  // Value for the next edge

   logic tick_a;        // Selected count clock A
   logic tick_b_src;    // Selected count clock B, separate mode
   logic cascade;       // Channels chained
   logic run_a;         // Counter A advances this cycle
   logic run_b;         // Counter B advances this cycle
   logic match_a;       // Counter A hits compare
   logic match_b;       // Counter B (or 16-bit pair) hits compare
   logic [7:0] out_wr;  // Value stored into output control
   logic out_hit;       // Store to output control

   // Clock field A picks channel A source
   count_tick_select sel_a (
      .presc     (st.presc),
      .sel       (st.clock_select[3:0]),
      .edge_now  (st.ext_s2[0]),
      .edge_prev (st.ext_s3[0]),
      .tick      (tick_a)
   );

   // Clock field B picks channel B source
   count_tick_select sel_b (
      .presc     (st.presc),
      .sel       (st.clock_select[7:4]),
      .edge_now  (st.ext_s2[1]),
      .edge_prev (st.ext_s3[1]),
      .tick      (tick_b_src)
   );

   // Counter advance and match decode
   always_comb begin
      cascade = st.mode[MODE_CASCADE_SELECT];
      // Cascaded pair runs on channel A enable alone
      run_a = tick_a & st.mode[MODE_COUNT_ENABLE_A];
      // In cascade B counts A overflow
      if (cascade) begin
         run_b = run_a && (st.counter_a == 8'hff);
      end else begin
         run_b = tick_b_src & st.mode[MODE_COUNT_ENABLE_B];
      end
      match_a = run_a && (st.counter_a == st.compare_a);
      if (cascade) begin
         match_b = match_a && (st.counter_b == st.compare_b);
      end else begin
         match_b = run_b && (st.counter_b == st.compare_b);
      end
      out_hit = (reg_wr | reg_bit_wr) && (reg_addr == ADDR_OUT_CONTROL);
      // Command bits are held at zero, so a bit store only fires its own command
      out_wr = merge_store({2'b00, st.invert_enable_b, st.out_enable_b, 2'b00,
                            st.invert_enable_a, st.out_enable_a},
                           reg_wdata, reg_bit_wr, reg_bit_sel, reg_bit_val);
   end

   // Next-state logic for registers, counters, flip-flops and pins
   always_comb begin
      next_st = st;
      next_st.presc = st.presc + 1'b1;
      // Two-flop synchronisers for asynchronous pins
      next_st.ext_s1 = {ext_count_in_b, ext_count_in_a};
      next_st.ext_s2 = st.ext_s1;
      next_st.ext_s3 = st.ext_s2;
      next_st.pin_s1 = port3_in;
      next_st.pin_s2 = st.pin_s1;

      // Register stores
      if (reg_wr && reg_addr == ADDR_CLOCK_SELECT) begin
         next_st.clock_select = reg_wdata;
      end
      // Mode control takes bit and byte stores
      if ((reg_wr | reg_bit_wr) && reg_addr == ADDR_MODE_CONTROL) begin
         next_st.mode = 3'(merge_store({5'b00000, st.mode}, reg_wdata, reg_bit_wr,
                                       reg_bit_sel, reg_bit_val));
      end
      // Channel B fields in the upper nibble
      if (out_hit) begin
         next_st.out_enable_a    = out_wr[OUT_ENABLE_A];
         next_st.invert_enable_a = out_wr[INVERT_ENABLE_A];
         next_st.out_enable_b    = out_wr[OUT_ENABLE_B];
         next_st.invert_enable_b = out_wr[INVERT_ENABLE_B];
      end
      if ((reg_wr | reg_bit_wr) && reg_addr == ADDR_PORT3_DIR) begin
         next_st.port3_direction = merge_store(st.port3_direction, reg_wdata, reg_bit_wr,
                                               reg_bit_sel, reg_bit_val);
      end
      if ((reg_wr | reg_bit_wr) && reg_addr == ADDR_PORT3_DATA) begin
         next_st.port3_latch = merge_store(st.port3_latch, reg_wdata, reg_bit_wr,
                                           reg_bit_sel, reg_bit_val);
      end
      if (reg_wr && reg_addr == ADDR_COMPARE_A) begin
         next_st.compare_a = reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_COMPARE_B) begin
         next_st.compare_b = reg_wdata;
      end

      // Match clears to zero, otherwise count on
      if (run_a) begin
         if (match_a && (!cascade || match_b)) begin
            next_st.counter_a = 8'h00;
         end else begin
            next_st.counter_a = st.counter_a + 8'h01;
         end
      end
      if (cascade && match_b) begin
         next_st.counter_b = 8'h00;
      end else if (run_b) begin
         next_st.counter_b = match_b ? 8'h00 : st.counter_b + 8'h01;
      end
      // Request pulses in the cycle after the match
      next_st.irq_a = match_a;
      next_st.irq_b = match_b;

      // Set/clear of flip-flop A wins over a toggle
      // Otherwise toggle A on match when allowed
      if (out_hit && out_wr[FF_SET_A] && !out_wr[FF_CLEAR_A]) begin
         next_st.output_latch_a = 1'b1;
      end else if (out_hit && out_wr[FF_CLEAR_A] && !out_wr[FF_SET_A]) begin
         next_st.output_latch_a = 1'b0;
      end else if (match_a && st.invert_enable_a) begin
         next_st.output_latch_a = ~st.output_latch_a;
      end
      if (out_hit && out_wr[FF_SET_B] && !out_wr[FF_CLEAR_B]) begin
         next_st.output_latch_b = 1'b1;
      end else if (out_hit && out_wr[FF_CLEAR_B] && !out_wr[FF_SET_B]) begin
         next_st.output_latch_b = 1'b0;
      end else if (match_b && st.invert_enable_b) begin
         next_st.output_latch_b = ~st.output_latch_b;
      end

      // Output enable hands the pin to the flip-flop
      next_st.pin_out = next_st.port3_latch;
      if (next_st.out_enable_a) begin
         next_st.pin_out[PIN_TIMER_OUT_A] = next_st.output_latch_a;
      end
      if (next_st.out_enable_b) begin
         next_st.pin_out[PIN_TIMER_OUT_B] = next_st.output_latch_b;
      end
      // Pin only driven once its direction bit is cleared
      next_st.pin_oe = ~next_st.port3_direction;

      // Read path, one cycle after the request
      // Command bits always read zero
      next_st.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_CLOCK_SELECT: next_st.rdata = st.clock_select;
            ADDR_MODE_CONTROL: next_st.rdata = {5'b00000, st.mode};
            ADDR_OUT_CONTROL:  next_st.rdata = {2'b00, st.invert_enable_b, st.out_enable_b,
                                                2'b00, st.invert_enable_a, st.out_enable_a};
            ADDR_PORT3_DIR:    next_st.rdata = st.port3_direction;
            // Output pins read their latch, input pins the synchronised level
            ADDR_PORT3_DATA:   next_st.rdata = (st.port3_latch & ~st.port3_direction)
                                               | (st.pin_s2 & st.port3_direction);
            ADDR_COMPARE_A:    next_st.rdata = st.compare_a;
            ADDR_COMPARE_B:    next_st.rdata = st.compare_b;
            ADDR_COUNTER_A:    next_st.rdata = st.counter_a;
            ADDR_COUNTER_B:    next_st.rdata = st.counter_b;
            default:           next_st.rdata = 8'h00;  // Unmapped reads zero
         endcase
      end
   end

   // State register; constants only under reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
         st.mode <= 3'(RESET_ZERO);
         // All port 3 pins start as inputs
         st.port3_direction <= RESET_PORT3_DIR;
         st.port3_latch <= RESET_ZERO;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata   = st.rdata;
   assign port3_out   = st.pin_out;
   assign port3_oe    = st.pin_oe;
   assign match_irq_a = st.irq_a;
   assign match_irq_b = st.irq_b;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence out_set_a_seq;
      reg_wr && reg_addr == ADDR_OUT_CONTROL && reg_wdata[FF_SET_A] && !reg_wdata[FF_CLEAR_A];
   endsequence
   sequence out_clear_a_seq;
      reg_wr && reg_addr == ADDR_OUT_CONTROL && reg_wdata[FF_CLEAR_A] && !reg_wdata[FF_SET_A];
   endsequence
   sequence out_read_seq;
      reg_rd && reg_addr == ADDR_OUT_CONTROL;
   endsequence

   cmd_read_zero_a: assert property (out_read_seq |=> reg_rdata[7:6] == 2'b00 && reg_rdata[3:2] == 2'b00)
      else $error("command bits read back nonzero");
   ff_set_a: assert property (out_set_a_seq |=> st.output_latch_a)
      else $error("set command did not set flip-flop A");
   ff_clear_a: assert property (out_clear_a_seq |=> !st.output_latch_a)
      else $error("clear command did not clear flip-flop A");
   match_clear_a: assert property (match_irq_a && !$past(cascade) |-> st.counter_a == 8'h00)
      else $error("counter A not zero with its request");
   hold_disabled_a: assert property (!st.mode[MODE_COUNT_ENABLE_A] |=> $stable(st.counter_a))
      else $error("counter A moved while disabled");
   step_one_a: assert property (run_a && !match_a |=> st.counter_a == $past(st.counter_a) + 8'h01)
      else $error("counter A did not step by one");
   toggle_on_a: assert property (match_a && st.invert_enable_a && !out_hit
                                 |=> st.output_latch_a != $past(st.output_latch_a))
      else $error("flip-flop A did not toggle on match");
   no_toggle_a: assert property (match_a && !st.invert_enable_a && !out_hit
                                 |=> $stable(st.output_latch_a))
      else $error("flip-flop A toggled with inversion off");
   pin_drive_a: assert property (st.out_enable_a |-> port3_out[PIN_TIMER_OUT_A] == st.output_latch_a)
      else $error("pin 1 not driven by flip-flop A");
   div4_tick_a: assert property (tick_a && st.clock_select[3:0] == 4'h6 |-> st.presc[1:0] == 2'b11)
      else $error("clk/4 tick off its prescaler phase");
   mode_bit_a: assert property (reg_bit_wr && reg_addr == ADDR_MODE_CONTROL && reg_bit_sel == 3'd2
                                |=> cascade == $past(reg_bit_val))
      else $error("bit store to cascade select lost");
   dir_bit_a: assert property (reg_bit_wr && reg_addr == ADDR_PORT3_DIR
                               |=> ##1 port3_oe[$past(reg_bit_sel, 2)] == !$past(reg_bit_val, 2))
      else $error("direction bit store not reflected on enable");

endmodule // byte_interval_timer

// ---- byte_interval_timer_tb.sv ----
// Self-checking testbench for the dual byte interval timer
`timescale 1ns/1ps
module byte_interval_timer_tb;
   import byte_timer_pkg::*;

   logic        clk            = 1'b0;     // 200 MHz system clock
   logic        reset_n        = 1'b0;     // Async reset, active low
   logic [15:0] reg_addr       = 16'h0000; // Register address
   logic        reg_wr         = 1'b0;     // Byte store strobe
   logic [7:0]  reg_wdata      = 8'h00;    // Byte store data
   logic        reg_bit_wr     = 1'b0;     // Bit store strobe
   logic [2:0]  reg_bit_sel    = 3'h0;     // Bit store index
   logic        reg_bit_val    = 1'b0;     // Bit store value
   logic        reg_rd         = 1'b0;     // Read strobe
   logic [7:0]  reg_rdata;                 // Read data
   logic        ext_count_in_a = 1'b0;     // External count pin A
   logic        ext_count_in_b = 1'b0;     // External count pin B
   logic [7:0]  port3_in       = 8'ha5;    // Port 3 pin levels, mixed pattern
   logic [7:0]  port3_out;                 // Port 3 output values
   logic [7:0]  port3_oe;                  // Port 3 output enables
   logic        match_irq_a;               // Match request A
   logic        match_irq_b;               // Match request B
   int          err_total       = 0;       // Mismatch count
   int          samples_checked = 0;       // Comparison count
   logic [7:0]  rd_val;                    // Last read value
   logic [7:0]  base;                      // Count before edge burst
   logic [15:0] reset_addr [6] = '{ADDR_CLOCK_SELECT, ADDR_MODE_CONTROL, ADDR_OUT_CONTROL,
                                   ADDR_PORT3_DIR, ADDR_COUNTER_A, ADDR_COUNTER_B};
   logic [7:0]  reset_val  [6] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};

   byte_interval_timer u_byte_interval_timer (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_bit_wr(reg_bit_wr), .reg_bit_sel(reg_bit_sel), .reg_bit_val(reg_bit_val),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_in_a(ext_count_in_a),
      .ext_count_in_b(ext_count_in_b), .port3_in(port3_in), .port3_out(port3_out),
      .port3_oe(port3_oe), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b)
   );

   // Clock, 5 ns period
   always #2.5 clk = ~clk;

   // Compare and count; widened so long periods fit
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      if (err_total == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Byte store, strobe held up to the taking edge
   task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // Single-bit store
   task automatic wr_bit(input logic [15:0] a, input logic [2:0] s, input logic v);
      @(posedge clk);
      reg_addr    <= a;
      reg_bit_sel <= s;
      reg_bit_val <= v;
      reg_bit_wr  <= 1'b1;
      @(posedge clk);
      reg_bit_wr  <= 1'b0;
   endtask

   // Read; data stands for one cycle after the taking edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Read and compare in one call
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check({8'h00, d}, {8'h00, exp});
   endtask

   // Let a store land, then look at one port 3 output bit
   task automatic pin_chk(input int b, input logic v);
      @(posedge clk);
      #1;
      check({15'h0, port3_out[b]}, {15'h0, v});
   endtask

   // Bounded wait for one match pulse of a channel
   task automatic wait_irq(input int ch, output int c);
      logic hit;
      c   = 0;
      hit = 1'b0;
      while (!hit && c < 5000) begin
         @(posedge clk);
         #1;
         c++;
         hit = ((ch == 1) ? match_irq_b : match_irq_a) === 1'b1;
      end
      check({15'h0, hit}, 16'h0001);
   endtask

   // Cycles between two matches; optional pin toggle check
   task automatic measure(input int ch, input int exp_period, input logic inv);
      int   c;
      logic pin0;
      wait_irq(ch, c);
      pin0 = port3_out[1 + ch];
      wait_irq(ch, c);
      check(c[15:0], exp_period[15:0]);
      if (inv) begin
         check({15'h0, port3_out[1 + ch]}, {15'h0, ~pin0});
      end
   endtask

   // Watchdog: whole run is well under this span
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      check({8'h00, port3_oe}, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         rd_chk(reset_addr[i], reset_val[i]);
      end
      rd_chk(16'hff00, 8'h00);
      // Bit store into mode register, then clear it again
      wr_bit(ADDR_MODE_CONTROL, 3'd0, 1'b1);
      rd_chk(ADDR_MODE_CONTROL, 8'h01);
      wr_bit(ADDR_MODE_CONTROL, 3'd0, 1'b0);
      // Cascaded pair from zero, B enable left off: 0x0101 + 1 ticks of clk/4
      wr_byte(ADDR_CLOCK_SELECT, 8'h06);
      wr_byte(ADDR_COMPARE_A, 8'h01);
      wr_byte(ADDR_COMPARE_B, 8'h01);
      wr_bit(ADDR_MODE_CONTROL, 3'd2, 1'b1);
      wr_bit(ADDR_MODE_CONTROL, 3'd0, 1'b1);
      rd_chk(ADDR_MODE_CONTROL, 8'h05);
      measure(1, 1032, 1'b0);
      wr_bit(ADDR_MODE_CONTROL, 3'd0, 1'b0);
      wr_bit(ADDR_MODE_CONTROL, 3'd2, 1'b0);
      // Every prescaled code with compare 0: one tick per interval
      wr_byte(ADDR_COMPARE_A, 8'h00);
      for (int code = 6; code <= 15; code++) begin
         wr_byte(ADDR_CLOCK_SELECT, {4'h0, code[3:0]});
         wr_bit(ADDR_MODE_CONTROL, 3'd0, 1'b1);
         measure(0, (code == 15) ? 4096 : (1 << (code - 4)), 1'b0);
         wr_bit(ADDR_MODE_CONTROL, 3'd0, 1'b0);
      end
      // Forbidden code must never tick; compare off zero so a tick would show
      wr_byte(ADDR_COMPARE_A, 8'hff);
      wr_byte(ADDR_CLOCK_SELECT, 8'h02);
      wr_bit(ADDR_MODE_CONTROL, 3'd0, 1'b1);
      repeat (100) @(posedge clk);
      rd_chk(ADDR_COUNTER_A, 8'h00);
      wr_byte(ADDR_MODE_CONTROL, 8'h00);
      // Timer pins as outputs with latches low
      wr_byte(ADDR_PORT3_DATA, 8'h00);
      wr_byte(ADDR_PORT3_DIR, 8'hf9);
      rd_chk(ADDR_PORT3_DIR, 8'hf9);
      check({8'h00, port3_oe}, 16'h0006);
      // Set while output is off leaves the pin on its latch
      wr_byte(ADDR_OUT_CONTROL, 8'h08);
      pin_chk(1, 1'b0);
      rd_chk(ADDR_OUT_CONTROL, 8'h00);
      wr_byte(ADDR_OUT_CONTROL, 8'h01);
      pin_chk(1, 1'b1);
      wr_byte(ADDR_OUT_CONTROL, 8'h05);
      pin_chk(1, 1'b0);
      wr_byte(ADDR_OUT_CONTROL, 8'h90);
      pin_chk(2, 1'b1);
      rd_chk(ADDR_OUT_CONTROL, 8'h10);
      wr_byte(ADDR_OUT_CONTROL, 8'h50);
      pin_chk(2, 1'b0);
      wr_byte(ADDR_OUT_CONTROL, 8'h33);
      rd_chk(ADDR_OUT_CONTROL, 8'h33);
      // Single-bit direction store, then mixed latch and pin read-back
      wr_bit(ADDR_PORT3_DIR, 3'd3, 1'b0);
      rd_chk(ADDR_PORT3_DIR, 8'hf1);
      check({8'h00, port3_oe}, 16'h000e);
      rd_chk(ADDR_PORT3_DATA, 8'ha1);
      // Both channels as interval timers with toggling outputs
      wr_byte(ADDR_CLOCK_SELECT, 8'h76);
      wr_byte(ADDR_COMPARE_A, 8'h03);
      wr_byte(ADDR_COMPARE_B, 8'h02);
      wr_byte(ADDR_MODE_CONTROL, 8'h03);
      rd_chk(ADDR_MODE_CONTROL, 8'h03);
      measure(0, 16, 1'b1);
      measure(1, 24, 1'b1);
      wr_byte(ADDR_MODE_CONTROL, 8'h00);
      // Edge counting, rising then falling code, on both channels
      for (int ch = 0; ch < 2; ch++) begin
         wr_byte(ADDR_COMPARE_A + ch, 8'hff);
         for (int e = 1; e >= 0; e--) begin
            rd(ADDR_COUNTER_A + ch, base);
            wr_byte(ADDR_CLOCK_SELECT, (ch == 1) ? {3'b000, e[0], 4'h6} : {4'h7, 3'b000, e[0]});
            wr_bit(ADDR_MODE_CONTROL, ch[2:0], 1'b1);
            repeat (5) begin
               @(posedge clk);
               if (ch == 1) ext_count_in_b <= 1'b1; else ext_count_in_a <= 1'b1;
               repeat (4) @(posedge clk);
               if (ch == 1) ext_count_in_b <= 1'b0; else ext_count_in_a <= 1'b0;
               repeat (4) @(posedge clk);
            end
            repeat (6) @(posedge clk);
            wr_bit(ADDR_MODE_CONTROL, ch[2:0], 1'b0);
            rd_chk(ADDR_COUNTER_A + ch, base + 8'h05);
            repeat (20) @(posedge clk);
            rd_chk(ADDR_COUNTER_A + ch, base + 8'h05);
         end
      end
      tally_and_finish();
   end

endmodule // byte_interval_timer_tb

// ---- byte_timer_pkg.sv ----
// Constants, register map and shared decode for the dual byte interval timer
package byte_timer_pkg;

   // Register addresses on the CPU memory map
   localparam logic [15:0] ADDR_CLOCK_SELECT = 16'hff41;  // count_clock_select
   localparam logic [15:0] ADDR_COMPARE_A    = 16'hff4a;  // compare_a
   localparam logic [15:0] ADDR_COMPARE_B    = 16'hff4b;  // compare_b
   localparam logic [15:0] ADDR_COUNTER_A    = 16'hff4c;  // counter_a, read only
   localparam logic [15:0] ADDR_COUNTER_B    = 16'hff4d;  // counter_b, read only
   localparam logic [15:0] ADDR_MODE_CONTROL = 16'hff48;  // timer_mode_control
   localparam logic [15:0] ADDR_OUT_CONTROL  = 16'hff4f;  // timer_output_control
   localparam logic [15:0] ADDR_PORT3_DIR    = 16'hff23;  // port3_direction
   localparam logic [15:0] ADDR_PORT3_DATA   = 16'hff03;  // port3 output latch / pin read

   // Reset values
   localparam logic [7:0] RESET_ZERO      = 8'h00;
   localparam logic [7:0] RESET_PORT3_DIR = 8'hff;

   // timer_mode_control bit positions
   localparam int MODE_COUNT_ENABLE_A = 0;
   localparam int MODE_COUNT_ENABLE_B = 1;
   localparam int MODE_CASCADE_SELECT = 2;

   // timer_output_control bit positions
   localparam int OUT_ENABLE_A    = 0;
   localparam int INVERT_ENABLE_A = 1;
   localparam int FF_CLEAR_A      = 2;
   localparam int FF_SET_A        = 3;
   localparam int OUT_ENABLE_B    = 4;
   localparam int INVERT_ENABLE_B = 5;
   localparam int FF_CLEAR_B      = 6;
   localparam int FF_SET_B        = 7;

   // Port 3 pins shared with the timer outputs
   localparam int PIN_TIMER_OUT_A = 1;
   localparam int PIN_TIMER_OUT_B = 2;

   // Count clock codes (4-bit field per channel)
   localparam logic [3:0] SEL_FALLING_EDGE = 4'h0;
   localparam logic [3:0] SEL_RISING_EDGE  = 4'h1;

   // Prescaler width covers the deepest division, clk/2^12
   localparam int PRESC_WIDTH = 12;

   // Mask of low prescaler bits that must all be one for a divided tick
   function automatic logic [PRESC_WIDTH-1:0] divide_mask(input logic [3:0] code);
      case (code)
         4'h6:    divide_mask = 12'h003;  // clk/2^2
         4'h7:    divide_mask = 12'h007;  // clk/2^3
         4'h8:    divide_mask = 12'h00f;  // clk/2^4
         4'h9:    divide_mask = 12'h01f;  // clk/2^5
         4'ha:    divide_mask = 12'h03f;  // clk/2^6
         4'hb:    divide_mask = 12'h07f;  // clk/2^7
         4'hc:    divide_mask = 12'h0ff;  // clk/2^8
         4'hd:    divide_mask = 12'h1ff;  // clk/2^9
         4'he:    divide_mask = 12'h3ff;  // clk/2^10
         4'hf:    divide_mask = 12'hfff;  // clk/2^12, one step skipped
         default: divide_mask = 12'h000;  // Forbidden codes never tick
      endcase
   endfunction

   // Byte or single-bit store into a register
   function automatic logic [7:0] merge_store(input logic [7:0] old, input logic [7:0] wdata,
                                              input logic bit_wr, input logic [2:0] sel,
                                              input logic val);
      merge_store = wdata;
      if (bit_wr) begin
         merge_store = old;
         merge_store[sel] = val;
      end
   endfunction

endpackage

// ---- count_tick_select.sv ----
// Count clock selection for one channel: prescaled clock or input edge
`timescale 1ns/1ps
module count_tick_select
   import byte_timer_pkg::*;
(
   input  wire logic [PRESC_WIDTH-1:0] presc,
   input  wire logic [3:0]             sel,
   input  wire logic                   edge_now,
   input  wire logic                   edge_prev,
   output logic                        tick
);
   logic [PRESC_WIDTH-1:0] mask;  // Low bits to test

   // One-cycle tick enable for the chosen source
   always_comb begin
      mask = divide_mask(sel);
      // Code 0 falling, 1 rising, then divisions
      case (sel)
         SEL_FALLING_EDGE: tick = edge_prev & ~edge_now;
         SEL_RISING_EDGE:  tick = ~edge_prev & edge_now;
         // Divided ticks from the prescaler mask
         // Zero mask means a forbidden code: no tick at all
         default:          tick = (mask != '0) && ((presc & mask) == mask);
      endcase
   end
endmodule // count_tick_select
